// ---- hdl/ucos_consts.vh ----
// Purpose: shared constants of the unit chain overrun sequencer
// Assumes: included by every design file by its bare name
// Notes:   unit codes double as indexes into per-unit vectors
`ifndef UCOS_CONSTS_VH
`define UCOS_CONSTS_VH

`define UCOS_CW          16
`define UCOS_CNT_ZERO    16'h0000
`define UCOS_CNT_ONE     16'h0001
`define UCOS_SES_W       8
`define UCOS_SES_ZERO    8'h00

`define UCOS_U_COMP      2'h0
`define UCOS_U_PAD       2'h1
`define UCOS_U_ENC       2'h2
`define UCOS_U_AUTH      2'h3
`define UCOS_SLOT_FIRST  2'h0
`define UCOS_SLOT_ONE    2'h1

`define UCOS_ORIGIN_SKIP 1'b0
`define UCOS_ORIGIN_PREV 1'b1

`define UCOS_ST_IDLE     3'h1
`define UCOS_ST_RUN      3'h2
`define UCOS_ST_FIN      3'h4

`define UCOS_MASK_NONE   4'h0
`define UCOS_BYTE_ZERO   8'h00

`endif

// ---- hdl/ucos_unit_ctr.v ----
// Purpose: skip and work counters of one processing unit
// Assumes: load and adv never fall in the same cycle
// Notes:   alter is combinational from held state; the top registers it
`timescale 1ns/100ps
`include "ucos_consts.vh"

module ucos_unit_ctr
(
    input  wire                   core_clk,
    input  wire                   rst,
    input  wire                   load,
    input  wire [`UCOS_CW-1:0]    skip_in,
    input  wire [`UCOS_CW-1:0]    work_in,
    input  wire                   origin_in,
    input  wire                   enable_in,
    input  wire                   adv,
    input  wire                   prev_done,
    output wire                   alter,
    output wire                   done
);

    reg [`UCOS_CW-1:0] skip_r;
    reg [`UCOS_CW-1:0] work_r;
    reg                origin_r;
    reg                enable_r;
    wire               started;

    // origin prev waits for the byte after the previous unit's last worked byte
    assign started = (skip_r == `UCOS_CNT_ZERO) &&
                     ((origin_r == `UCOS_ORIGIN_SKIP) || prev_done);
    assign alter   = enable_r && started && (work_r != `UCOS_CNT_ZERO);
    assign done    = !enable_r || (work_r == `UCOS_CNT_ZERO);

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            skip_r   <= `UCOS_CNT_ZERO;
            work_r   <= `UCOS_CNT_ZERO;
            origin_r <= `UCOS_ORIGIN_SKIP;
            enable_r <= 1'b0;
        end
        else if (load)
        begin
            skip_r   <= skip_in;
            work_r   <= work_in;
            origin_r <= origin_in;
            enable_r <= enable_in;
        end
        else if (adv)
        begin
            if (skip_r != `UCOS_CNT_ZERO)
                skip_r <= skip_r - `UCOS_CNT_ONE;
            else if (alter)
                work_r <= work_r - `UCOS_CNT_ONE;
        end
    end

endmodule

// ---- hdl/ucos_sequencer.v ----
// Purpose: byte sequencer for a four unit chain with destination overrun handling
// Assumes: all inputs come from logic on core_clk; one byte per accepted source beat
// Notes:   destination bytes equal chain input bytes; units change data outside
`timescale 1ns/100ps
`include "ucos_consts.vh"

module ucos_sequencer
(
    input  wire                   core_clk,
    input  wire                   rst,
    input  wire                   cmd_valid,
    output reg                    cmd_ready,
    input  wire                   cmd_encode,
    input  wire [1:0]             cmd_auth_slot,
    input  wire [3:0]             cmd_unit_enable,
    input  wire [3:0]             cmd_count_origin,
    input  wire [`UCOS_CW-1:0]    cmd_comp_skip,
    input  wire [`UCOS_CW-1:0]    cmd_enc_skip,
    input  wire [`UCOS_CW-1:0]    cmd_auth_skip,
    input  wire [`UCOS_CW-1:0]    cmd_comp_work,
    input  wire [`UCOS_CW-1:0]    cmd_pad_work,
    input  wire [`UCOS_CW-1:0]    cmd_enc_work,
    input  wire [`UCOS_CW-1:0]    cmd_auth_work,
    input  wire [`UCOS_CW-1:0]    command_byte_total,
    input  wire [`UCOS_CW-1:0]    output_byte_limit,
    input  wire                   skip_output_limit,
    input  wire [`UCOS_SES_W-1:0] cmd_session,
    input  wire                   fresh_key_flag,
    input  wire                   fresh_vector_flag,
    input  wire                   src_valid,
    input  wire [7:0]             src_data,
    output reg                    src_ready,
    output reg                    dst_valid,
    output reg  [7:0]             dst_data,
    output reg  [3:0]             dst_alter,
    input  wire                   dst_ready,
    input  wire                   comp_out_strobe,
    input  wire                   desc_overrun_enable,
    input  wire                   desc_len_valid,
    input  wire [`UCOS_CW-1:0]    desc_len,
    input  wire                   unit_irq_enable,
    input  wire                   unit_irq_gate,
    input  wire                   excess_irq_enable,
    input  wire                   unit_flag_clear,
    input  wire                   excess_clear,
    output reg                    unit_overflow_live,
    output reg                    unit_overflow_flag,
    output reg                    excess_mark,
    output reg                    unit_irq,
    output reg                    excess_irq,
    output reg                    result_valid,
    output reg                    result_unit_overflow,
    output reg                    result_excess_mark,
    output reg  [`UCOS_CW-1:0]    result_comp_bytes,
    output reg                    desc_wb_excess,
    output reg                    desc_wb_valid,
    output reg                    ctx_reload,
    output reg                    ctx_load_fresh,
    output reg                    ctx_store_cipher,
    output reg                    ctx_store_comp,
    output reg                    engine_update
);

    reg [2:0]             state_r;
    reg [2:0]             state_nxt;
    reg [`UCOS_CW-1:0]    total_r;
    reg [`UCOS_CW-1:0]    dst_left_r;
    reg [`UCOS_CW-1:0]    room_r;
    reg [`UCOS_CW-1:0]    comp_bytes_r;
    reg                   encode_r;
    reg [1:0]             auth_slot_r;
    reg                   skip_limit_r;
    reg                   unit_ovr_r;
    reg                   excess_r;
    reg [3:0]             enable_r;
    reg [`UCOS_SES_W-1:0] last_session_r;
    reg                   session_known_r;
    reg [3:0]             prev_done;
    reg                   dst_valid_nxt;
    wire [3:0]            unit_alter;
    wire [3:0]            unit_done;
    wire                  start;
    wire                  take;
    wire                  unit_hit;
    wire                  desc_hit;
    wire                  emit;
    wire                  drained;
    wire [`UCOS_CW-1:0]   skip_vec [0:3];
    wire [`UCOS_CW-1:0]   work_vec [0:3];
    integer               k;

    // unit placed at a chain slot; decode runs the base order backwards
    function [1:0] unit_at;
        input [1:0] slot;
        input       enc;
        input [1:0] aslot;
        reg   [1:0] b;
        begin
            b = (slot > aslot) ? slot - `UCOS_SLOT_ONE : slot;
            if (slot == aslot)
                unit_at = `UCOS_U_AUTH;
            else if (b == `UCOS_SLOT_FIRST)
                unit_at = enc ? `UCOS_U_COMP : `UCOS_U_ENC;
            else if (b == `UCOS_SLOT_ONE)
                unit_at = `UCOS_U_PAD;
            else
                unit_at = enc ? `UCOS_U_ENC : `UCOS_U_COMP;
        end
    endfunction

    assign start    = state_r[0] && cmd_valid && cmd_ready;
    assign take     = state_r[1] && src_valid && src_ready;
    // once hit, the overrun drops every later byte of the command
    assign unit_hit = !skip_limit_r && (unit_ovr_r || dst_left_r == `UCOS_CNT_ZERO);
    assign desc_hit = desc_overrun_enable && (excess_r || room_r == `UCOS_CNT_ZERO);
    assign emit     = take && !unit_hit && !desc_hit;
    assign drained  = !dst_valid || dst_ready;

    assign skip_vec[0] = cmd_comp_skip;
    assign skip_vec[1] = cmd_enc_skip;
    assign skip_vec[2] = cmd_enc_skip;
    assign skip_vec[3] = cmd_auth_skip;
    assign work_vec[0] = cmd_comp_work;
    assign work_vec[1] = cmd_pad_work;
    assign work_vec[2] = cmd_enc_work;
    assign work_vec[3] = cmd_auth_work;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : unit
            ucos_unit_ctr u_ctr
            (
                .core_clk  (core_clk),
                .rst       (rst),
                .load      (start),
                .skip_in   (skip_vec[g]),
                .work_in   (work_vec[g]),
                .origin_in (cmd_count_origin[g]),
                .enable_in (cmd_unit_enable[g]),
                .adv       (take),
                .prev_done (prev_done[g]),
                .alter     (unit_alter[g]),
                .done      (unit_done[g])
            );
        end
    endgenerate

    // chain neighbour of each unit; the first slot has no predecessor
    always @*
    begin
        prev_done = 4'hF;
        for (k = 1; k < 4; k = k + 1)
            prev_done[unit_at(k[1:0], encode_r, auth_slot_r)] =
                unit_done[unit_at(k[1:0] - `UCOS_SLOT_ONE, encode_r, auth_slot_r)];
    end

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            `UCOS_ST_IDLE:
                if (start)
                    state_nxt = (command_byte_total == `UCOS_CNT_ZERO) ? `UCOS_ST_FIN : `UCOS_ST_RUN;
            `UCOS_ST_RUN:
                if (take && total_r == `UCOS_CNT_ONE)
                    state_nxt = `UCOS_ST_FIN;
            `UCOS_ST_FIN:
                if (drained)
                    state_nxt = `UCOS_ST_IDLE;
            default:
                state_nxt = `UCOS_ST_IDLE;
        endcase
    end

    always @*
    begin
        if (emit)
            dst_valid_nxt = 1'b1;
        else
            dst_valid_nxt = dst_valid && !dst_ready;
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r   <= `UCOS_ST_IDLE;
            cmd_ready <= 1'b0;
            src_ready <= 1'b0;
            dst_valid <= 1'b0;
            dst_data  <= `UCOS_BYTE_ZERO;
            dst_alter <= `UCOS_MASK_NONE;
        end
        else
        begin
            state_r   <= state_nxt;
            cmd_ready <= (state_nxt == `UCOS_ST_IDLE) && !start;
            // one byte in flight keeps the ready a flop without a skid buffer
            src_ready <= (state_nxt == `UCOS_ST_RUN) && !dst_valid_nxt && !take;
            dst_valid <= dst_valid_nxt;
            if (emit)
            begin
                dst_data  <= src_data;
                dst_alter <= unit_alter;
            end
        end
    end

    // per command counters and settings
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            total_r      <= `UCOS_CNT_ZERO;
            dst_left_r   <= `UCOS_CNT_ZERO;
            room_r       <= `UCOS_CNT_ZERO;
            comp_bytes_r <= `UCOS_CNT_ZERO;
            encode_r     <= 1'b0;
            auth_slot_r  <= `UCOS_SLOT_FIRST;
            skip_limit_r <= 1'b0;
            unit_ovr_r   <= 1'b0;
            excess_r     <= 1'b0;
            enable_r     <= `UCOS_MASK_NONE;
        end
        else if (start)
        begin
            total_r      <= command_byte_total;
            dst_left_r   <= output_byte_limit;
            comp_bytes_r <= `UCOS_CNT_ZERO;
            encode_r     <= cmd_encode;
            auth_slot_r  <= cmd_auth_slot;
            skip_limit_r <= skip_output_limit;
            unit_ovr_r   <= 1'b0;
            excess_r     <= 1'b0;
            enable_r     <= cmd_unit_enable;
            if (desc_len_valid)
                room_r <= room_r + desc_len;
        end
        else
        begin
            if (take)
                total_r <= total_r - `UCOS_CNT_ONE;
            if (comp_out_strobe)
                comp_bytes_r <= comp_bytes_r + `UCOS_CNT_ONE;
            if (emit && dst_left_r != `UCOS_CNT_ZERO)
                dst_left_r <= dst_left_r - `UCOS_CNT_ONE;
            if (take && unit_hit)
                unit_ovr_r <= 1'b1;
            if (take && desc_hit)
                excess_r <= 1'b1;
            // room is consumed only by bytes that reach the destination
            if (desc_len_valid)
                room_r <= room_r + desc_len - (emit ? `UCOS_CNT_ONE : `UCOS_CNT_ZERO);
            else if (emit && room_r != `UCOS_CNT_ZERO)
                room_r <= room_r - `UCOS_CNT_ONE;
        end
    end

    // status flags; a new event wins over a clear in the same cycle
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            unit_overflow_live <= 1'b0;
            unit_overflow_flag <= 1'b0;
            excess_mark        <= 1'b0;
            unit_irq           <= 1'b0;
            excess_irq         <= 1'b0;
        end
        else
        begin
            unit_overflow_live <= take && unit_hit && !unit_ovr_r;
            if (take && unit_hit && !unit_ovr_r)
                unit_overflow_flag <= 1'b1;
            else if (unit_flag_clear)
                unit_overflow_flag <= 1'b0;
            if (take && desc_hit && !excess_r)
                excess_mark <= 1'b1;
            else if (excess_clear)
                excess_mark <= 1'b0;
            unit_irq   <= unit_overflow_flag && unit_irq_enable && unit_irq_gate;
            excess_irq <= excess_mark && excess_irq_enable;
        end
    end

    // session tracking and context traffic
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            last_session_r  <= `UCOS_SES_ZERO;
            session_known_r <= 1'b0;
            ctx_reload      <= 1'b0;
            ctx_load_fresh  <= 1'b0;
        end
        else
        begin
            ctx_reload     <= start && (!session_known_r || cmd_session != last_session_r);
            ctx_load_fresh <= start && (fresh_key_flag || fresh_vector_flag);
            if (start)
            begin
                last_session_r  <= cmd_session;
                session_known_r <= 1'b1;
            end
        end
    end

    // results and write-back, issued once the last byte has left
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            result_valid         <= 1'b0;
            result_unit_overflow <= 1'b0;
            result_excess_mark   <= 1'b0;
            result_comp_bytes    <= `UCOS_CNT_ZERO;
            desc_wb_excess       <= 1'b0;
            desc_wb_valid        <= 1'b0;
            ctx_store_cipher     <= 1'b0;
            ctx_store_comp       <= 1'b0;
            engine_update        <= 1'b0;
        end
        else if (state_r[2] && drained)
        begin
            result_valid         <= 1'b1;
            result_unit_overflow <= unit_ovr_r;
            result_excess_mark   <= excess_r;
            result_comp_bytes    <= comp_bytes_r;
            desc_wb_excess       <= excess_r;
            desc_wb_valid        <= !excess_r;
            ctx_store_cipher     <= !unit_ovr_r && (enable_r[`UCOS_U_ENC] || enable_r[`UCOS_U_AUTH]);
            ctx_store_comp       <= enable_r[`UCOS_U_COMP];
            engine_update        <= enable_r[`UCOS_U_ENC];
        end
        else
        begin
            result_valid     <= 1'b0;
            desc_wb_excess   <= 1'b0;
            desc_wb_valid    <= 1'b0;
            ctx_store_cipher <= 1'b0;
            ctx_store_comp   <= 1'b0;
            engine_update    <= 1'b0;
        end
    end

endmodule

// ---- tb/ucos_sequencer_assertions.sv ----
// Purpose: concurrent checks on the sequencer ports
// Assumes: single core_clk domain, rst synchronous active high
// Notes:   bound to every ucos_sequencer instance
`timescale 1ns/100ps

module ucos_seq_chk
(
    input wire core_clk,
    input wire rst,
    input wire cmd_ready,
    input wire dst_valid,
    input wire unit_overflow_live,
    input wire unit_overflow_flag,
    input wire excess_mark,
    input wire unit_irq,
    input wire excess_irq,
    input wire unit_irq_enable,
    input wire unit_irq_gate,
    input wire excess_irq_enable,
    input wire unit_flag_clear,
    input wire excess_clear,
    input wire result_valid,
    input wire result_unit_overflow,
    input wire result_excess_mark,
    input wire desc_wb_excess,
    input wire desc_wb_valid,
    input wire ctx_store_cipher
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_unit_irq_gate: assert property (unit_irq ==
        $past(unit_overflow_flag && unit_irq_enable && unit_irq_gate))
        else $error("unit interrupt does not follow flag and both enables");
    chk_excess_irq_en: assert property (excess_irq == $past(excess_mark && excess_irq_enable))
        else $error("excess interrupt does not follow mark and enable");
    chk_live_one_cycle: assert property (unit_overflow_live |=> !unit_overflow_live)
        else $error("live overrun pulse longer than one cycle");
    chk_live_sets_flag: assert property (unit_overflow_live |-> ##[0:1] unit_overflow_flag)
        else $error("sticky overrun flag not set after live pulse");
    // a second reset may drop the flags, so it counts as a clear
    chk_flag_sticky: assert property ($fell(unit_overflow_flag) |-> $past(unit_flag_clear || rst))
        else $error("overrun flag dropped without a clear");
    chk_excess_sticky: assert property ($fell(excess_mark) |-> $past(excess_clear || rst))
        else $error("excess mark dropped without a clear");
    chk_drop_byte: assert property (unit_overflow_live |-> !dst_valid)
        else $error("byte written to destination during overrun");
    chk_wb_one_kind: assert property (result_valid |-> (desc_wb_excess != desc_wb_valid))
        else $error("descriptor write-back not exactly one of excess or valid");
    chk_ctx_blocked: assert property (result_valid && result_unit_overflow |-> !ctx_store_cipher)
        else $error("cipher context stored after unit overrun");
    chk_next_cmd: assert property (result_valid |=> cmd_ready)
        else $error("sequencer not ready one cycle after result");

    cover property (result_valid && result_unit_overflow);
    cover property (result_valid && desc_wb_excess);
    cover property (unit_irq && excess_irq_enable);
endmodule

bind ucos_sequencer ucos_seq_chk u_chk (.*);

// ---- tb/ucos_dma_model.sv ----
// Purpose: source and destination side model of the dma controller
// Assumes: one source byte offered per command byte, pattern A0 plus index
// Notes:   stall toggles dst_ready so destination bytes must be held
`timescale 1ns/100ps

module ucos_dma_model
(
    input  wire        core_clk,
    input  wire        rst,
    input  wire        restart,
    input  wire [15:0] command_byte_total,
    input  wire        stall,
    output reg         src_valid,
    output reg  [7:0]  src_data,
    input  wire        src_ready,
    input  wire        dst_valid,
    input  wire [7:0]  dst_data,
    input  wire [3:0]  dst_alter,
    output reg         dst_ready,
    output reg  [15:0] rcv
);
    reg [15:0] sent;
    reg [7:0]  got_data [0:15];
    reg [3:0]  got_alter [0:15];

    // released data is inverted so a stale byte never looks valid
    always @(posedge core_clk)
    begin
        if (rst || restart)
        begin
            src_valid <= 1'b0;
            src_data <= 8'h5A;
            sent <= 16'h0000;
        end
        else if (src_valid && src_ready)
        begin
            src_valid <= 1'b0;
            src_data <= ~src_data;
            sent <= sent + 16'h0001;
        end
        else if (!src_valid && sent < command_byte_total)
        begin
            src_valid <= 1'b1;
            src_data <= 8'hA0 + sent[7:0];
        end
    end

    always @(posedge core_clk)
    begin
        if (rst || restart)
        begin
            dst_ready <= 1'b0;
            rcv <= 16'h0000;
        end
        else
        begin
            dst_ready <= stall ? ~dst_ready : 1'b1;
            if (dst_valid && dst_ready)
            begin
                got_data[rcv[3:0]] <= dst_data;
                got_alter[rcv[3:0]] <= dst_alter;
                rcv <= rcv + 16'h0001;
            end
        end
    end
endmodule

// ---- tb/test_ucos_sequencer.sv ----
// Purpose: self-checking bench of the unit chain overrun sequencer
// Assumes: dma model supplies the source bytes and takes destination bytes
// Notes:   alter tables hold one nibble per byte, byte 0 lowest
`timescale 1ns/100ps

module test_ucos_sequencer;
    reg         core_clk, rst, cmd_valid, cmd_encode, skip_output_limit, fresh_key_flag, fresh_vector_flag;
    reg         comp_out_strobe, desc_overrun_enable, desc_len_valid, unit_irq_enable, unit_irq_gate;
    reg         excess_irq_enable, unit_flag_clear, excess_clear, restart, stall;
    reg  [1:0]  cmd_auth_slot, seen;
    reg  [3:0]  cmd_unit_enable, cmd_count_origin;
    reg  [4:0]  snap;
    reg  [7:0]  cmd_session;
    reg  [15:0] cmd_comp_skip, cmd_enc_skip, cmd_auth_skip, cmd_comp_work, cmd_pad_work, cmd_enc_work;
    reg  [15:0] cmd_auth_work, command_byte_total, output_byte_limit, desc_len;
    wire        cmd_ready, src_valid, src_ready, dst_valid, dst_ready, unit_overflow_live, unit_overflow_flag;
    wire        excess_mark, unit_irq, excess_irq, result_valid, result_unit_overflow, result_excess_mark;
    wire        desc_wb_excess, desc_wb_valid, ctx_reload, ctx_load_fresh, ctx_store_cipher, ctx_store_comp;
    wire        engine_update;
    wire [3:0]  dst_alter;
    wire [7:0]  src_data, dst_data;
    wire [15:0] result_comp_bytes, rcv;
    integer     num_errors = 0;
    integer     total_checks = 0;

    ucos_sequencer DUT (.*);
    ucos_dma_model pm (.*);

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task check(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
            end
        end
    endtask

    task results;
        begin
            $display("checks %0d errors %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    task set_cmd(input e, input [1:0] sl, input [3:0] en, input [3:0] org, input [15:0] cs, input [15:0] es,
                 input [15:0] cw, input [15:0] pw, input [15:0] ew, input [15:0] aw, input [15:0] tot,
                 input [7:0] ses);
        begin
            {cmd_encode, cmd_auth_slot, cmd_unit_enable, cmd_count_origin} = {e, sl, en, org};
            {cmd_comp_skip, cmd_enc_skip, cmd_auth_skip} = {cs, es, 16'h0000};
            {cmd_comp_work, cmd_pad_work, cmd_enc_work, cmd_auth_work} = {cw, pw, ew, aw};
            {command_byte_total, cmd_session} = {tot, ses};
        end
    endtask

    // compressed output strobes are sent up to three times per command, once in a zero-total command
    task run_cmd;
        integer n;
        begin
            restart = 1'b1;
            @(negedge core_clk);
            {restart, cmd_valid, seen, n} = {1'b0, 1'b1, 2'b00, 32'h0};
            while (cmd_ready !== 1'b1 && n < 20)
            begin
                @(negedge core_clk);
                n = n + 1;
            end
            @(negedge core_clk);
            {cmd_valid, n} = {1'b0, 32'h0};
            while (result_valid !== 1'b1 && n < 300)
            begin
                seen = seen | {ctx_reload, ctx_load_fresh};
                comp_out_strobe = (n < 3);
                @(negedge core_clk);
                n = n + 1;
            end
            comp_out_strobe = 1'b0;
            seen = seen | {ctx_reload, ctx_load_fresh};
            snap = {ctx_store_cipher, ctx_store_comp, engine_update, desc_wb_excess, desc_wb_valid};
            check(n < 300, 1);
        end
    endtask

    task check_stream(input integer n, input [31:0] alt);
        integer i;
        begin
            check(rcv, n);
            for (i = 0; i < n; i = i + 1)
            begin
                check(pm.got_data[i], 8'hA0 + i);
                check(pm.got_alter[i], alt[4*i +: 4]);
            end
        end
    endtask

    task pulse_clear(input u);
        begin
            {unit_flag_clear, excess_clear} = {u, !u};
            @(negedge core_clk);
            {unit_flag_clear, excess_clear} = 2'b00;
            repeat (2) @(negedge core_clk);
        end
    endtask

    // comp disabled, pad skip from encryption fields, auth slot 3 chained after enc
    task t_encode_chain;
        begin
            stall = 1'b1;
            set_cmd(1, 3, 4'hE, 4'h8, 0, 2, 4, 1, 3, 2, 8, 1);
            run_cmd;
            stall = 1'b0;
            check_stream(8, 32'h08844600);
            check(result_comp_bytes, 3);
            check(seen, 2'b10);
            check(snap, 5'b10101);
            check({result_unit_overflow, result_excess_mark}, 0);
        end
    endtask

    task t_decode_order;
        begin
            set_cmd(0, 0, 4'h3, 4'h1, 0, 0, 2, 2, 0, 0, 5, 1);
            run_cmd;
            check_stream(5, 32'h00001122);
            check(seen, 2'b00);
            check(snap, 5'b01001);
        end
    endtask

    task t_unit_overrun;
        begin
            {output_byte_limit, unit_irq_enable} = {16'h0003, 1'b1};
            set_cmd(1, 3, 4'h5, 4'h0, 0, 0, 0, 0, 0, 0, 6, 2);
            run_cmd;
            check_stream(3, 0);
            check(seen, 2'b10);
            check(snap, 5'b01101);
            check({result_unit_overflow, unit_overflow_flag, unit_irq}, 3'b110);
            unit_irq_gate = 1'b1;
            repeat (2) @(negedge core_clk);
            check(unit_irq, 1);
            pulse_clear(1'b1);
            check({unit_overflow_flag, unit_irq}, 0);
            {skip_output_limit, fresh_vector_flag} = 2'b11;
            run_cmd;
            {skip_output_limit, fresh_vector_flag} = 2'b00;
            check_stream(6, 0);
            check(seen, 2'b01);
            check({snap[4], unit_overflow_flag}, 2'b10);
        end
    endtask

    task t_zero_total;
        begin
            fresh_key_flag = 1'b1;
            set_cmd(1, 3, 4'hC, 4'h0, 0, 0, 0, 0, 0, 0, 0, 3);
            run_cmd;
            fresh_key_flag = 1'b0;
            check(rcv, 0);
            check(seen, 2'b11);
            check(snap, 5'b10101);
        end
    endtask

    // both overrun kinds on; the descriptor room runs out first
    task t_desc_overrun;
        begin
            {desc_overrun_enable, excess_irq_enable, output_byte_limit} = {2'b11, 16'h000A};
            {desc_len, desc_len_valid} = {16'h0004, 1'b1};
            @(negedge core_clk);
            desc_len_valid = 1'b0;
            set_cmd(1, 3, 4'h5, 4'h0, 0, 0, 0, 0, 0, 0, 6, 3);
            run_cmd;
            check_stream(4, 0);
            check(snap[1:0], 2'b10);
            check({result_excess_mark, result_unit_overflow, excess_mark}, 3'b101);
            @(negedge core_clk);
            check(excess_irq, 1);
            pulse_clear(1'b0);
            check({excess_mark, excess_irq}, 0);
        end
    endtask

    initial
    begin
        {rst, cmd_valid, skip_output_limit, fresh_key_flag, fresh_vector_flag, comp_out_strobe} = 6'h3F & 6'h20;
        {desc_overrun_enable, desc_len_valid, unit_irq_enable, unit_irq_gate, excess_irq_enable} = 5'h00;
        // a zero limit would count every byte as overrun, so start with room for the longest stream
        {unit_flag_clear, excess_clear, restart, stall, output_byte_limit, desc_len} = {4'h0, 16'h0010, 16'h0000};
        set_cmd(0, 0, 4'h0, 4'h0, 0, 0, 0, 0, 0, 0, 0, 0);
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        t_encode_chain;
        t_decode_order;
        t_unit_overrun;
        t_zero_total;
        t_desc_overrun;
        results;
    end

    // six short commands need well under 1000 cycles
    initial
    begin
        #20000;
        num_errors = num_errors + 1;
        results;
    end
endmodule
